// ===== design/rbs_rise_blank_top.sv
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - Mask bit 7 set blanks the external event input during blanking.
// - Mask bit 3 set blanks synchronized comparator three during blanking.
// - Mask bit 2 set blanks synchronized comparator two during blanking.
// - Mask bit 1 set blanks synchronized comparator one during blanking.
// - Bits six to four and zero read zero; writes there ignored.
// - Mask bits are read/write and clear to zero on any reset.
// - Mode 00 no blanking, 01 immediate; 10 and 11 reserved.

module rbs_rise_blank_top
(
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic [rbs_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [rbs_pkg::DATA_W-1:0]  avs_writedata,
   input  wire logic [rbs_pkg::BE_W-1:0]    avs_byteenable,
   output logic      [rbs_pkg::DATA_W-1:0]  avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic                        extEventInput,
   input  wire logic [rbs_pkg::NUM_CMP-1:0] cmpOutRaw,
   input  wire logic                        riseEdgeStart,
   output logic      [rbs_pkg::NUM_SRC-1:0] gatedSources,
   output logic                             sourceEvent,
   output logic                             blankActive
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic regHit
   (
      input logic [rbs_pkg::ADDR_W-1:0] addr,
      input logic [rbs_pkg::ADDR_W-1:0] ofs
   );
      regHit = (addr == ofs);
   endfunction : regHit

   function automatic logic modeBlanks
   (
      input logic [rbs_pkg::BLANK_MODE_W-1:0] mode
   );
      // Reserved codes behave as no blanking
      modeBlanks = (mode == rbs_pkg::RBS_MODE_IMMEDIATE);
   endfunction : modeBlanks

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [rbs_pkg::REG_W-1:0]   srcMask_q;
   logic [rbs_pkg::REG_W-1:0]   blankCtl_q;
   logic [rbs_pkg::REG_W-1:0]   blankLen_q;
   logic [rbs_pkg::REG_W-1:0]   blankCnt_q;
   logic [rbs_pkg::REG_W-1:0]   blankCnt_d;
   logic [rbs_pkg::DATA_W-1:0]  readData_q;
   logic [rbs_pkg::DATA_W-1:0]  readData_d;
   logic                        waitReq_q;
   logic [rbs_pkg::NUM_CMP-1:0] cmpSynced;
   logic [rbs_pkg::NUM_SRC-1:0] srcLevel;
   logic [rbs_pkg::NUM_SRC-1:0] srcMaskBits;
   logic [rbs_pkg::NUM_SRC-1:0] gated_d;
   logic [rbs_pkg::NUM_SRC-1:0] gated_q;
   logic                        srcEvent_q;
   logic                        blankActive_q;
   logic                        blankNow;
   logic                        accessGo;
   logic                        writeGo;
   logic                        wrLow;
   logic [rbs_pkg::REG_W-1:0]   wrByte;
   logic [rbs_pkg::BLANK_MODE_W-1:0] riseMode;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronizers

   genvar gi;
   generate
      for (gi = 0; gi < rbs_pkg::NUM_CMP; gi++)
      begin : gCmpSync
         rbs_sync2 uSync
         (
            .clk     (clk),
            .rst_b   (rst_b),
            .asyncIn (cmpOutRaw[gi]),
            .syncOut (cmpSynced[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave handshake

   // Request held one cycle with waitrequest high, then taken
   assign accessGo = (avs_read | avs_write) & waitReq_q;
   assign writeGo  = avs_write & ~waitReq_q;
   assign wrLow    = writeGo & avs_byteenable[0];
   assign wrByte   = avs_writedata[rbs_pkg::REG_W-1:0];

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waitReq_q <= 1'b1;
      end
      else if (accessGo)
      begin
         waitReq_q <= 1'b0;
      end
      else
      begin
         waitReq_q <= 1'b1;
      end
   end

   always_comb
   begin
      readData_d = '0;
      if (regHit(avs_address, rbs_pkg::OFS_SRC_MASK))
      begin
         readData_d[rbs_pkg::REG_W-1:0] = srcMask_q & rbs_pkg::SRC_MASK_WR_BITS;
      end
      else if (regHit(avs_address, rbs_pkg::OFS_BLANK_CTL))
      begin
         readData_d[rbs_pkg::REG_W-1:0] = blankCtl_q & rbs_pkg::BLANK_CTL_WR_BITS;
      end
      else if (regHit(avs_address, rbs_pkg::OFS_BLANK_LEN))
      begin
         readData_d[rbs_pkg::REG_W-1:0] = blankLen_q;
      end
      else if (regHit(avs_address, rbs_pkg::OFS_STATUS))
      begin
         readData_d[rbs_pkg::BIT_STAT_BLANK] = blankActive_q;
         readData_d[rbs_pkg::STAT_SRC_LSB +: rbs_pkg::NUM_SRC] = srcLevel;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         readData_q <= '0;
      end
      else if (accessGo & avs_read)
      begin
         readData_q <= readData_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         srcMask_q <= rbs_pkg::SRC_MASK_RESET;
      end
      else if (wrLow & regHit(avs_address, rbs_pkg::OFS_SRC_MASK))
      begin
         srcMask_q <= wrByte & rbs_pkg::SRC_MASK_WR_BITS;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         blankCtl_q <= rbs_pkg::BLANK_CTL_RESET;
      end
      else if (wrLow & regHit(avs_address, rbs_pkg::OFS_BLANK_CTL))
      begin
         blankCtl_q <= wrByte & rbs_pkg::BLANK_CTL_WR_BITS;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         blankLen_q <= rbs_pkg::BLANK_LEN_RESET;
      end
      else if (wrLow & regHit(avs_address, rbs_pkg::OFS_BLANK_LEN))
      begin
         blankLen_q <= wrByte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blanking interval

   assign riseMode = blankCtl_q[rbs_pkg::BLANK_MODE_LSB +: rbs_pkg::BLANK_MODE_W];

   always_comb
   begin
      blankCnt_d = blankCnt_q;
      if (!modeBlanks(riseMode))
      begin
         blankCnt_d = '0;
      end
      else if (riseEdgeStart)
      begin
         blankCnt_d = blankLen_q;
      end
      else if (blankCnt_q != '0)
      begin
         blankCnt_d = blankCnt_q - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         blankCnt_q <= '0;
      end
      else
      begin
         blankCnt_q <= blankCnt_d;
      end
   end

   assign blankNow = (blankCnt_q != '0);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         blankActive_q <= 1'b0;
      end
      else
      begin
         blankActive_q <= blankNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source gating

   // Order: cmp1, cmp2, cmp3, external input
   assign srcLevel = {extEventInput, cmpSynced};

   assign srcMaskBits[0] = srcMask_q[rbs_pkg::BIT_MASK_CMP1];
   assign srcMaskBits[1] = srcMask_q[rbs_pkg::BIT_MASK_CMP2];
   assign srcMaskBits[2] = srcMask_q[rbs_pkg::BIT_MASK_CMP3];
   assign srcMaskBits[3] = srcMask_q[rbs_pkg::BIT_MASK_INPUT_PIN];

   // A masked source passes only outside the blanking interval
   assign gated_d = srcLevel & ~(srcMaskBits & {rbs_pkg::NUM_SRC{blankNow}});

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gated_q <= '0;
      end
      else
      begin
         gated_q <= gated_d;
      end
   end

   // One-cycle pulse on any newly passing source
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         srcEvent_q <= 1'b0;
      end
      else
      begin
         srcEvent_q <= |(gated_d & ~gated_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign avs_readdata    = readData_q;
   assign avs_waitrequest = waitReq_q;
   assign gatedSources    = gated_q;
   assign sourceEvent     = srcEvent_q;
   assign blankActive     = blankActive_q;

endmodule : rbs_rise_blank_top

// ===== include/rbs_pkg.sv
package rbs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W   = 4;
   localparam int unsigned REG_W  = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [3:0] OFS_SRC_MASK  = 4'h0;
   localparam logic [3:0] OFS_BLANK_CTL = 4'h4;
   localparam logic [3:0] OFS_BLANK_LEN = 4'h8;
   localparam logic [3:0] OFS_STATUS    = 4'hC;

   ////////////////////////////////////////////////////////////////////////////
   // Source mask fields
   localparam int unsigned BIT_MASK_INPUT_PIN = 7;
   localparam int unsigned BIT_MASK_CMP3      = 3;
   localparam int unsigned BIT_MASK_CMP2      = 2;
   localparam int unsigned BIT_MASK_CMP1      = 1;
   localparam logic [7:0]  SRC_MASK_WR_BITS   = 8'h8E;
   localparam logic [7:0]  SRC_MASK_RESET     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Blanking control fields
   localparam int unsigned BLANK_MODE_LSB    = 0;
   localparam int unsigned BLANK_MODE_W      = 2;
   localparam logic [7:0]  BLANK_CTL_WR_BITS = 8'h03;
   localparam logic [7:0]  BLANK_CTL_RESET   = 8'h00;
   localparam logic [7:0]  BLANK_LEN_RESET   = 8'h00;

   typedef enum logic [1:0]
   {
      RBS_MODE_NONE      = 2'h0,
      RBS_MODE_IMMEDIATE = 2'h1,
      RBS_MODE_RSVD2     = 2'h2,
      RBS_MODE_RSVD3     = 2'h3
   } rbs_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Status fields
   localparam int unsigned BIT_STAT_BLANK   = 0;
   localparam int unsigned STAT_SRC_LSB     = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Sources
   localparam int unsigned NUM_CMP = 3;
   localparam int unsigned NUM_SRC = 4;

endpackage : rbs_pkg

// ===== design/rbs_sync2.sv
`timescale 1ns/1ps

module rbs_sync2
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic asyncIn,
   output logic      syncOut
);

   logic stage1_q;
   logic stage2_q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
      end
      else
      begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule : rbs_sync2

// ===== test/rbs_rise_blank_assertions.sv
`timescale 1ns/1ps

module rbs_rise_blank_assertions
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        extEventInput,
   input wire logic [2:0]  cmpOutRaw,
   input wire logic        riseEdgeStart,
   input wire logic [3:0]  gatedSources,
   input wire logic        sourceEvent,
   input wire logic        blankActive
);
   logic [1:0] upCnt_q;

   // Edges seen since reset release, saturating
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b) upCnt_q <= 2'h0;
      else if (upCnt_q != 2'h3) upCnt_q <= upCnt_q + 2'h1;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
      else $error("bus request not answered");
   no_spurious_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   rd_upper_a: assert property (avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   ext_pass_a: assert property (upCnt_q != 2'h0 && !blankActive |-> gatedSources[3] == $past(extEventInput))
      else $error("input pin not passed outside blanking");
   cmp_pass_a: assert property (upCnt_q == 2'h3 && !blankActive |-> gatedSources[2:0] == $past(cmpOutRaw, 3))
      else $error("comparators not passed after sync");
   ext_gate_a: assert property (upCnt_q != 2'h0 && gatedSources[3] |-> $past(extEventInput))
      else $error("gated pin above its source");
   blank_start_a: assert property ($rose(blankActive) |-> $past(riseEdgeStart, 2))
      else $error("blanking without rising edge");
   event_pulse_a: assert property (upCnt_q != 2'h0 |-> sourceEvent == |(gatedSources & ~$past(gatedSources)))
      else $error("event pulse mismatch");

   cover property ($rose(blankActive));
   cover property (blankActive && gatedSources == 4'h0);
   cover property (avs_write && !avs_waitrequest);
endmodule : rbs_rise_blank_assertions

bind rbs_rise_blank_top rbs_rise_blank_assertions chk_i
(
   .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .extEventInput(extEventInput), .cmpOutRaw(cmpOutRaw), .riseEdgeStart(riseEdgeStart),
   .gatedSources(gatedSources), .sourceEvent(sourceEvent), .blankActive(blankActive)
);

// ===== test/rbs_src_model.sv
`timescale 1ns/1ps

module rbs_src_model
(
   input  wire logic       clk,
   input  wire logic [3:0] level,
   output logic            extEventInput,
   output logic [2:0]      cmpOutRaw
);
   // Pin and comparators follow the requested levels
   always @(posedge clk)
      {extEventInput, cmpOutRaw} <= level;
endmodule : rbs_src_model

// ===== test/testbench.sv
`timescale 1ns/1ps

module testbench;
   logic        clk, rst_b, avs_read, avs_write, riseEdgeStart, avs_waitrequest;
   logic        extEventInput, sourceEvent, blankActive, bl;
   logic [3:0]  avs_address, avs_byteenable, level, gatedSources, a, s;
   logic [2:0]  cmpOutRaw;
   logic [31:0] avs_writedata, avs_readdata, rd, d;
   int          mismatches, comparisons, len;

   rbs_rise_blank_top uut
   (
      .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .extEventInput(extEventInput), .cmpOutRaw(cmpOutRaw), .riseEdgeStart(riseEdgeStart),
      .gatedSources(gatedSources), .sourceEvent(sourceEvent), .blankActive(blankActive)
   );
   rbs_src_model src (.clk(clk), .level(level), .extEventInput(extEventInput), .cmpOutRaw(cmpOutRaw));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      {avs_address, avs_writedata, avs_byteenable} <= {ad, wd, be};
      {avs_read, avs_write} <= {!wr, wr};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      {avs_read, avs_write} <= 2'h0;
      if (n >= 20)
      begin
         mismatches++;
         wrap_up();
      end
   endtask : bus

   function automatic logic [31:0] expReg(logic [3:0] ad, logic [31:0] wd);
      if (ad == rbs_pkg::OFS_SRC_MASK) return {24'h0, wd[7:0] & rbs_pkg::SRC_MASK_WR_BITS};
      if (ad == rbs_pkg::OFS_BLANK_CTL) return {24'h0, wd[7:0] & rbs_pkg::BLANK_CTL_WR_BITS};
      if (ad == rbs_pkg::OFS_BLANK_LEN) return {24'h0, wd[7:0]};
      return 32'h0;
   endfunction : expReg

   initial
   begin
      {avs_read, avs_write, riseEdgeStart, rst_b} = 4'h0;
      {avs_address, avs_writedata, level} = 40'h0;
      avs_byteenable = 4'hF;
      void'($urandom(32'h34D6));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b0, 4'(4 * i), 32'h0, 4'hF);
         chk("reset", rd, 32'h0);
      end
      repeat (16)
      begin
         {a, d} = {4'($urandom), $urandom};
         if (a == rbs_pkg::OFS_STATUS) a = 4'h1;
         level <= 4'($urandom);
         bus(1'b1, a, d, 4'hF);
         bus(1'b0, a, 32'h0, 4'hF);
         chk("reg", rd, expReg(a, d));
      end
      bus(1'b1, 4'h0, 32'h8E, 4'hF);
      bus(1'b1, 4'h0, 32'h00, 4'h0);
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      chk("be", rd, 32'h8E);
      level <= 4'hF;
      for (int m = 0; m < 4; m++)
         repeat (3)
         begin
            {s, len} = {4'($urandom), $urandom_range(1, 5)};
            bus(1'b1, rbs_pkg::OFS_SRC_MASK, {24'h0, s[3], 3'h0, s[2:0], 1'b0}, 4'hF);
            bus(1'b1, rbs_pkg::OFS_BLANK_CTL, 32'(m), 4'hF);
            bus(1'b1, rbs_pkg::OFS_BLANK_LEN, 32'(len), 4'hF);
            @(posedge clk) riseEdgeStart <= 1'b1;
            @(posedge clk) riseEdgeStart <= 1'b0;
            for (int k = 1; k <= len + 2; k++)
            begin
               bl = (m == 1) && k >= 2 && k <= len + 1;
               @(negedge clk);
               chk("gated", gatedSources, 4'hF & ~({4{bl}} & s));
               chk("blank", blankActive, bl);
               chk("event", sourceEvent, (m == 1) && (s != 4'h0) && (k == len + 2));
               @(posedge clk);
            end
         end
      bus(1'b0, rbs_pkg::OFS_STATUS, 32'h0, 4'hF);
      chk("status", rd, 32'h0000001E);
      rst_b <= 1'b0;
      @(posedge clk) rst_b <= 1'b1;
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      chk("rerst", rd, 32'h0);
      wrap_up();
   end
endmodule : testbench
